// File: include/pmsr_consts.svh
// Function
// RULE_01 - 7 check bits per 32, 8 per 64
// RULE_02 - reads correct single, detect double errors
// RULE_03 - double error: word passed uncorrected, flagged
// RULE_04 - uncorrectable bus read gets error response
// RULE_05 - uncorrectable error with enable raises interrupt
// RULE_06 - transmit path forwards corrupt data, interrupts
// RULE_07 - each memory owns status, enable, count, injection
// RULE_08 - injection corrupts later writes by 1-3 bits
// RULE_09 - optional check byte in extra lane
// RULE_10 - saturating count, separate sticky status flags
// RULE_11 - master discards data with error response
`ifndef PMSR_CONSTS_SVH
`define PMSR_CONSTS_SVH

`define PMSR_CHK32 7
`define PMSR_CHK64 8
`define PMSR_DW_A 32
`define PMSR_DW_B 64
`define PMSR_CNT_W 16
`define PMSR_INJ_W 2
`define PMSR_EADDR_W 16

`define PMSR_BLK_A 2'h0
`define PMSR_BLK_B 2'h1
`define PMSR_BLK_CTRL 2'h2

`define PMSR_OFS_STAT 5'h00
`define PMSR_OFS_INTEN 5'h04
`define PMSR_OFS_CNT 5'h08
`define PMSR_OFS_INJ 5'h0C
`define PMSR_OFS_EADDR 5'h10
`define PMSR_OFS_CTRL 5'h00

`define PMSR_STAT_CE 0
`define PMSR_STAT_UE 1
`define PMSR_CTRL_EXT 0

`define PMSR_RST_EXT 1'h1
`define PMSR_RST_WAIT 1'h1

`define PMSR_RESP_OK 2'h0
`define PMSR_RESP_SLVERR 2'h2

`endif

// File: include/pmsr_pkg.sv
`include "pmsr_consts.svh"

package pmsr_pkg;

  typedef struct packed {
    logic [`PMSR_EADDR_W-1:0] eaddr;
    logic [`PMSR_INJ_W-1:0] inj;
    logic [`PMSR_CNT_W-1:0] cnt;
    logic [1:0] inten;
    logic [1:0] stat;
  } pmsr_csr_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [`PMSR_DW_A-1:0] data;
  } pmsr_ares_t;

  typedef struct packed {
    logic valid;
    logic corrupt;
    logic [`PMSR_DW_B-1:0] data;
  } pmsr_bres_t;

  typedef struct packed {
    pmsr_csr_t csr_a;
    pmsr_csr_t csr_b;
    logic ext_en;
    logic wreq;
    logic [31:0] rdata;
    logic [1:0] resp;
    pmsr_ares_t ares;
    pmsr_bres_t bres;
    logic irq;
  } pmsr_state_t;

endpackage

// File: hw/pmsr_secded.sv
`timescale 1ns/1ns
`include "pmsr_consts.svh"

module pmsr_secded #(
  parameter int DW = 32,
  localparam int CW = (DW > 32) ? `PMSR_CHK64 : `PMSR_CHK32,
  localparam int R = CW - 1
) (
  input wire logic [DW-1:0] enc_data,
  output logic [CW-1:0] enc_check,
  input wire logic [DW-1:0] dec_data,
  input wire logic [CW-1:0] dec_check,
  output logic [DW-1:0] dec_fixed,
  output logic dec_ce,
  output logic dec_ue
);

  // hamming position of data bit j: powers of two are left to check bits
  function automatic int dpos(input int j);
    int k;
    int p;
    dpos = 0;
    k = 0;
    for (p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (k == j && dpos == 0) begin
          dpos = p;
        end
        k++;
      end
    end
  endfunction

  function automatic logic [R-1:0] hsum(input logic [DW-1:0] d);
    logic [R-1:0] h;
    int p;
    h = '0;
    for (int j = 0; j < DW; j++) begin
      p = dpos(j);
      for (int i = 0; i < R; i++) begin
        if (p[i]) begin
          h[i] = h[i] ^ d[j];
        end
      end
    end
    return h;
  endfunction

  logic [R-1:0] enc_h;
  logic [R-1:0] syn;
  logic par;

  // overall parity sits in the top check bit
  assign enc_h = hsum(enc_data);
  assign enc_check = {^{enc_h, enc_data}, enc_h}; // RULE_01

  assign syn = hsum(dec_data) ^ dec_check[R-1:0];
  assign par = ^{dec_data, dec_check};
  assign dec_ce = par; // RULE_02
  assign dec_ue = !par && (syn != '0); // RULE_02

  // a double error leaves the word untouched, flagging only
  always_comb begin
    dec_fixed = dec_data;
    for (int j = 0; j < DW; j++) begin
      if (par && syn == R'(dpos(j))) begin
        dec_fixed[j] = !dec_data[j]; // RULE_03
      end
    end
  end

endmodule

// File: hw/pmsr_top.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "pmsr_consts.svh"

module pmsr_top #(
  parameter int A_DEPTH = 256,
  parameter int B_DEPTH = 256,
  localparam int AAW = $clog2(A_DEPTH),
  localparam int BAW = $clog2(B_DEPTH)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  input wire logic a_req,
  input wire logic a_we,
  input wire logic [AAW-1:0] a_addr,
  input wire logic [`PMSR_DW_A-1:0] a_wdata,
  output pmsr_pkg::pmsr_ares_t a_res,
  input wire logic b_wr,
  input wire logic [BAW-1:0] b_waddr,
  input wire logic [`PMSR_DW_B-1:0] b_wdata,
  input wire logic b_rd,
  input wire logic [BAW-1:0] b_raddr,
  output pmsr_pkg::pmsr_bres_t b_res,
  output logic irq
);

  localparam int AW_W = `PMSR_DW_A + `PMSR_CHK32;
  localparam int BW_W = `PMSR_DW_B + `PMSR_CHK64;

  pmsr_pkg::pmsr_state_t s;
  pmsr_pkg::pmsr_state_t next_s;

  // protected arrays: memory A feeds a bus reader, memory B a transmit path
  logic [AW_W-1:0] mem_a [A_DEPTH];
  logic [BW_W-1:0] mem_b [B_DEPTH];

  logic [`PMSR_CHK32-1:0] a_chk;
  logic [`PMSR_CHK64-1:0] b_chk;
  logic [`PMSR_CHK64-1:0] b_lane;
  logic [AW_W-1:0] a_store;
  logic [BW_W-1:0] b_store;
  logic [AW_W-1:0] a_raw;
  logic [BW_W-1:0] b_raw;
  logic [`PMSR_DW_A-1:0] a_fix;
  logic [`PMSR_DW_B-1:0] b_fix;
  logic a_dce;
  logic a_due;
  logic b_dce;
  logic b_due;
  logic a_ce;
  logic a_ue;
  logic b_ce;
  logic b_ue;
  logic [1:0] blk;
  logic [4:0] off;
  logic mapped;
  logic taken;
  logic wr_a;
  logic wr_b;
  logic wr_ctrl;

  function automatic logic [2:0] inj_mask(input logic [`PMSR_INJ_W-1:0] n);
    inj_mask = {n == 2'h3, n >= 2'h2, n != 2'h0};
  endfunction

  function automatic logic [31:0] csr_rd(input pmsr_pkg::pmsr_csr_t c, input logic [4:0] o);
    case (o)
      `PMSR_OFS_STAT: csr_rd = {30'h0, c.stat};
      `PMSR_OFS_INTEN: csr_rd = {30'h0, c.inten};
      `PMSR_OFS_CNT: csr_rd = {16'h0, c.cnt};
      `PMSR_OFS_INJ: csr_rd = {30'h0, c.inj};
      `PMSR_OFS_EADDR: csr_rd = {16'h0, c.eaddr};
      default: csr_rd = 32'h0;
    endcase
  endfunction

  // one control set per memory, same update for both
  function automatic pmsr_pkg::pmsr_csr_t csr_upd(
    input pmsr_pkg::pmsr_csr_t c,
    input logic wr,
    input logic [4:0] o,
    input logic [31:0] wd,
    input logic ce,
    input logic ue,
    input logic [`PMSR_EADDR_W-1:0] ea
  );
    pmsr_pkg::pmsr_csr_t n;
    n = c;
    if (wr) begin
      case (o)
        `PMSR_OFS_STAT: n.stat = c.stat & ~wd[1:0];
        `PMSR_OFS_INTEN: n.inten = wd[1:0];
        `PMSR_OFS_CNT: n.cnt = '0;
        `PMSR_OFS_INJ: n.inj = wd[`PMSR_INJ_W-1:0];
        default: n = c;
      endcase
    end
    // an event in the clearing cycle still lands: set wins
    if (ce || ue) begin
      if (n.cnt != '1) begin
        n.cnt = n.cnt + 1'b1; // RULE_10
      end
      n.eaddr = ea;
    end
    n.stat = n.stat | {ue, ce}; // RULE_10
    return n;
  endfunction

  pmsr_secded #(
    .DW(`PMSR_DW_A)
  ) u_codec_a (
    .enc_data(a_wdata),
    .enc_check(a_chk),
    .dec_data(a_raw[`PMSR_DW_A-1:0]),
    .dec_check(a_raw[AW_W-1:`PMSR_DW_A]),
    .dec_fixed(a_fix),
    .dec_ce(a_dce),
    .dec_ue(a_due)
  );

  pmsr_secded #(
    .DW(`PMSR_DW_B)
  ) u_codec_b (
    .enc_data(b_wdata),
    .enc_check(b_chk),
    .dec_data(b_raw[`PMSR_DW_B-1:0]),
    .dec_check(b_raw[BW_W-1:`PMSR_DW_B]),
    .dec_fixed(b_fix),
    .dec_ce(b_dce),
    .dec_ue(b_due)
  );

  // injected bits land in the low data bits so software can predict them
  assign a_store = {a_chk, a_wdata} ^ {{(AW_W-3){1'b0}}, inj_mask(s.csr_a.inj)}; // RULE_08
  // check byte lane is written as zero while lane protection is off
  assign b_lane = s.ext_en ? b_chk : '0; // RULE_09
  assign b_store = {b_lane, b_wdata} ^ {{(BW_W-3){1'b0}}, inj_mask(s.csr_b.inj)}; // RULE_08

  assign a_raw = mem_a[a_addr];
  assign b_raw = mem_b[b_raddr];

  assign a_ce = a_req && !a_we && a_dce; // RULE_02
  assign a_ue = a_req && !a_we && a_due; // RULE_02
  assign b_ce = b_rd && s.ext_en && b_dce; // RULE_09
  assign b_ue = b_rd && s.ext_en && b_due; // RULE_09

  always_ff @(posedge clk_sys) begin
    if (a_req && a_we) begin
      mem_a[a_addr] <= a_store; // RULE_01
    end
    if (b_wr) begin
      mem_b[b_waddr] <= b_store; // RULE_01
    end
  end

  assign blk = avs_address[6:5];
  assign off = avs_address[4:0];
  assign mapped = ((blk == `PMSR_BLK_A || blk == `PMSR_BLK_B)
                   && off <= `PMSR_OFS_EADDR && off[1:0] == 2'h0)
                  || (blk == `PMSR_BLK_CTRL && off == `PMSR_OFS_CTRL);
  // a write acts only at the edge where waitrequest is seen low
  assign taken = avs_write && !s.wreq;
  assign wr_a = taken && mapped && blk == `PMSR_BLK_A; // RULE_07
  assign wr_b = taken && mapped && blk == `PMSR_BLK_B; // RULE_07
  assign wr_ctrl = taken && mapped && blk == `PMSR_BLK_CTRL;

  always_comb begin
    next_s = s;
    // one wait cycle per request, then back to waiting
    next_s.wreq = !((avs_read || avs_write) && s.wreq);
    if (avs_read && s.wreq) begin
      next_s.resp = mapped ? `PMSR_RESP_OK : `PMSR_RESP_SLVERR;
      if (!mapped) begin
        next_s.rdata = 32'h0;
      end else if (blk == `PMSR_BLK_A) begin
        next_s.rdata = csr_rd(s.csr_a, off);
      end else if (blk == `PMSR_BLK_B) begin
        next_s.rdata = csr_rd(s.csr_b, off);
      end else begin
        next_s.rdata = {31'h0, s.ext_en};
      end
    end
    next_s.csr_a = csr_upd(s.csr_a, wr_a, off, avs_writedata, a_ce, a_ue,
                           `PMSR_EADDR_W'(a_addr)); // RULE_07
    next_s.csr_b = csr_upd(s.csr_b, wr_b, off, avs_writedata, b_ce, b_ue,
                           `PMSR_EADDR_W'(b_raddr)); // RULE_07
    if (wr_ctrl) begin
      next_s.ext_en = avs_writedata[`PMSR_CTRL_EXT]; // RULE_09
    end
    next_s.ares.valid = a_req && !a_we;
    next_s.ares.err = a_ue; // RULE_04
    if (a_req && !a_we) begin
      next_s.ares.data = a_fix; // RULE_03
    end
    next_s.bres.valid = b_rd;
    next_s.bres.corrupt = b_ue; // RULE_06
    if (b_rd) begin
      // with lane protection off the stored word is returned raw
      next_s.bres.data = s.ext_en ? b_fix : b_raw[`PMSR_DW_B-1:0]; // RULE_06
    end
    // transmit-path uncorrectable errors interrupt regardless of enable
    next_s.irq = |(next_s.csr_a.stat & next_s.csr_a.inten)
                 || |(next_s.csr_b.stat & next_s.csr_b.inten)
                 || next_s.csr_b.stat[`PMSR_STAT_UE]; // RULE_05 RULE_06
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.wreq <= `PMSR_RST_WAIT;
      s.ext_en <= `PMSR_RST_EXT;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_response = s.resp;
  assign avs_waitrequest = s.wreq;
  assign a_res = s.ares;
  assign b_res = s.bres;
  assign irq = s.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence seq_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence seq_a_evt;
    (a_ce || a_ue) && !wr_a;
  endsequence

  sequence seq_tx_bad;
    b_res.valid && b_res.corrupt;
  endsequence

  sequence seq_rd_seen;
    avs_read && avs_waitrequest;
  endsequence

  AST_BUS_ANSWER: assert property ( // RULE_07
    seq_req_wait |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after exactly one wait cycle");

  AST_CE_FIX: assert property ( // RULE_02
    a_ce |=> a_res.valid && !a_res.err
             && $countones(a_res.data ^ $past(a_raw[`PMSR_DW_A-1:0])) <= 1)
    else $error("single error not corrected to one bit");

  AST_UE_PASS: assert property ( // RULE_03
    a_ue |=> a_res.data == $past(a_raw[`PMSR_DW_A-1:0]))
    else $error("double error word was altered");

  AST_UE_ERR: assert property ( // RULE_04
    a_ue |=> a_res.valid && a_res.err)
    else $error("uncorrectable read missing error response");

  AST_CLEAN_OK: assert property ( // RULE_04
    a_req && !a_we && !a_ue |=> a_res.valid && !a_res.err)
    else $error("error response without uncorrectable error");

  AST_UE_IRQ: assert property ( // RULE_05
    a_ue && s.csr_a.inten[`PMSR_STAT_UE] && !wr_a |=> irq)
    else $error("enabled uncorrectable error raised no interrupt");

  AST_TX_CORRUPT: assert property ( // RULE_06
    b_ue |=> seq_tx_bad ##0 irq)
    else $error("transmit corrupt data not flagged with interrupt");

  AST_INJ_BITS: assert property ( // RULE_08
    a_req && a_we |-> $countones(a_store ^ {a_chk, a_wdata}) == int'(s.csr_a.inj))
    else $error("injected bit count differs from setting");

  AST_LANE_OFF: assert property ( // RULE_09
    b_wr && !s.ext_en |-> b_store[BW_W-1:`PMSR_DW_B] == '0)
    else $error("check lane written while protection off");

  AST_CNT_STEP: assert property ( // RULE_10
    seq_a_evt ##0 (s.csr_a.cnt != '1) |=> s.csr_a.cnt == $past(s.csr_a.cnt) + 16'h0001)
    else $error("error count did not step by one");

  AST_CNT_SAT: assert property ( // RULE_10
    s.csr_a.cnt == '1 && !wr_a |=> s.csr_a.cnt == '1)
    else $error("error count wrapped");

  AST_UE_STICKY: assert property ( // RULE_10
    s.csr_a.stat[`PMSR_STAT_UE] && !wr_a |=> s.csr_a.stat[`PMSR_STAT_UE])
    else $error("uncorrected flag dropped without clear");

  AST_RD_UNMAPPED: assert property ( // RULE_07
    seq_rd_seen ##0 !mapped |=> avs_response == `PMSR_RESP_SLVERR && avs_readdata == 32'h0)
    else $error("unmapped read not refused");

  AST_RD_MAPPED: assert property ( // RULE_07
    seq_rd_seen ##0 mapped |=> avs_response == `PMSR_RESP_OK)
    else $error("mapped read refused");

  AST_CE_FLAG: assert property ( // RULE_10
    a_ce |=> s.csr_a.stat[`PMSR_STAT_CE])
    else $error("corrected event not recorded");

  AST_UE_FLAG: assert property ( // RULE_10
    a_ue |=> s.csr_a.stat[`PMSR_STAT_UE])
    else $error("uncorrected event not recorded");

  AST_CE_STICKY: assert property ( // RULE_10
    s.csr_a.stat[`PMSR_STAT_CE] && !wr_a |=> s.csr_a.stat[`PMSR_STAT_CE])
    else $error("corrected flag dropped without clear");

  AST_CNT_CLR: assert property ( // RULE_10
    wr_a && off == `PMSR_OFS_CNT && !a_ce && !a_ue |=> s.csr_a.cnt == '0)
    else $error("error count not cleared by write");

  AST_EADDR: assert property ( // RULE_07
    a_ce || a_ue |=> s.csr_a.eaddr == `PMSR_EADDR_W'($past(a_addr)))
    else $error("error address not captured");

  AST_B_INDEP: assert property ( // RULE_07
    !b_ce && !b_ue && !wr_b |=> $stable(s.csr_b))
    else $error("memory B controls changed without own cause");

  AST_B_UE_FLAG: assert property ( // RULE_10
    b_ue |=> s.csr_b.stat[`PMSR_STAT_UE] && irq)
    else $error("transmit uncorrected event not recorded");

  AST_B_CLEAN: assert property ( // RULE_06
    b_rd && !b_ue |=> b_res.valid && !b_res.corrupt)
    else $error("transmit word flagged corrupt without cause");

  AST_B_UE_PASS: assert property ( // RULE_03
    b_ue |=> b_res.data == $past(b_raw[`PMSR_DW_B-1:0]))
    else $error("transmit double error word was altered");

  AST_B_CE_FIX: assert property ( // RULE_02
    b_ce |=> b_res.valid && !b_res.corrupt
             && $countones(b_res.data ^ $past(b_raw[`PMSR_DW_B-1:0])) <= 1)
    else $error("transmit single error not corrected to one bit");

  AST_LANE_RAW: assert property ( // RULE_09
    b_rd && !s.ext_en |=> !b_res.corrupt && b_res.data == $past(b_raw[`PMSR_DW_B-1:0]))
    else $error("unprotected word not passed raw");

  AST_B_INJ_BITS: assert property ( // RULE_08
    b_wr |-> $countones(b_store ^ {b_lane, b_wdata}) == int'(s.csr_b.inj))
    else $error("transmit injected bit count differs from setting");

  AST_IRQ_A_UE: assert property ( // RULE_05
    s.csr_a.stat[`PMSR_STAT_UE] && s.csr_a.inten[`PMSR_STAT_UE] |-> irq)
    else $error("enabled uncorrected status without interrupt");

endmodule

// File: tb/pmsr_master_model.sv
`timescale 1ns/1ns

module pmsr_master_model (
  input wire logic clk_sys,
  input wire logic rst,
  input pmsr_pkg::pmsr_ares_t a_res,
  output int n_used,
  output int n_dropped
);
  // a word carrying a bus error is never used; a real master would retry or trap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      n_used <= 0;
      n_dropped <= 0;
    end else if (a_res.valid === 1'b1) begin
      if (a_res.err === 1'b1) begin
        n_dropped <= n_dropped + 1;
      end else begin
        n_used <= n_used + 1;
      end
    end
  end
endmodule

// File: tb/test_peripheral_memory_secded_reporting.sv
`timescale 1ns/1ns
`include "pmsr_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s: expected %h, seen %h", nm, e, g); end end

module test_peripheral_memory_secded_reporting;
  logic clk_sys, rst, avs_read, avs_write, a_req, a_we, b_wr, b_rd, irq, avs_waitrequest;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, d;
  logic [1:0] avs_response, rs;
  logic [3:0] a_addr, b_waddr, b_raddr;
  logic [31:0] a_wdata;
  logic [63:0] b_wdata, e;
  pmsr_pkg::pmsr_ares_t a_res;
  pmsr_pkg::pmsr_bres_t b_res;
  logic [32:0] qa[$];
  logic [64:0] qb[$];
  logic [32:0] xa;
  logic [64:0] xb;
  int n_errors = 0, n_checks = 0, seed = 32'hdba7, n_used, n_dropped;

  pmsr_top #(.A_DEPTH(16), .B_DEPTH(16)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .a_req(a_req), .a_we(a_we), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_res(a_res), .b_wr(b_wr), .b_waddr(b_waddr), .b_wdata(b_wdata),
    .b_rd(b_rd), .b_raddr(b_raddr), .b_res(b_res), .irq(irq));

  pmsr_master_model u_master (.clk_sys(clk_sys), .rst(rst), .a_res(a_res),
    .n_used(n_used), .n_dropped(n_dropped));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // results are matched in order against what the driver noted
  always @(posedge clk_sys) begin
    if (a_res.valid === 1'b1) begin
      xa = qa.size() ? qa.pop_front() : 33'hX;
      `CHK("a_res", xa, {a_res.err, a_res.data})
    end
    if (b_res.valid === 1'b1) begin
      xb = qb.size() ? qb.pop_front() : 65'hX;
      `CHK("b_res", xb, {b_res.corrupt, b_res.data})
    end
  end

  task automatic av(input logic wr, input logic [6:0] ad, input logic [31:0] wd);
    int k;
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= ad;
    avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) n_errors++;
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [6:0] ad, input logic [31:0] ex, input string nm);
    av(1'b0, ad, 32'h0);
    `CHK(nm, ex, rd)
    `CHK("response", `PMSR_RESP_OK, rs)
  endtask

  task automatic mem_a(input logic we, input logic [3:0] ad, input logic [31:0] dd,
                       input logic er);
    @(posedge clk_sys);
    a_req <= 1'b1;
    a_we <= we;
    a_addr <= ad;
    a_wdata <= dd;
    if (!we) qa.push_back({er, dd});
    @(posedge clk_sys);
    a_req <= 1'b0;
  endtask

  task automatic mem_b(input logic we, input logic [3:0] ad, input logic [63:0] dd,
                       input logic er);
    @(posedge clk_sys);
    b_wr <= we;
    b_rd <= !we;
    b_waddr <= ad;
    b_raddr <= ad;
    b_wdata <= dd;
    if (!we) qb.push_back({er, dd});
    @(posedge clk_sys);
    b_wr <= 1'b0;
    b_rd <= 1'b0;
  endtask

  task final_report;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(4 * 5000);
    n_errors++;
    final_report();
  end

  initial begin
    {avs_read, avs_write, a_req, a_we, b_wr, b_rd} = '0;
    {avs_address, avs_writedata, a_addr, a_wdata, b_waddr, b_raddr, b_wdata} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(7'h40, 32'h1, "ctrl");
    rchk(7'h00, 32'h0, "stat_a");
    av(1'b0, 7'h60, 32'h0);
    `CHK("unmapped", {2'h2, 32'h0}, {rs, rd})
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      mem_a(1'b1, i[3:0], d, 1'b0);
      mem_a(1'b0, i[3:0], d, 1'b0);
    end
    $display("test clean done");
    d = $random(seed);
    av(1'b1, 7'h0C, 32'h1);
    mem_a(1'b1, 4'h5, d, 1'b0);
    av(1'b1, 7'h0C, 32'h0);
    mem_a(1'b0, 4'h5, d, 1'b0);
    rchk(7'h00, 32'h1, "stat_a");
    rchk(7'h08, 32'h1, "cnt_a");
    rchk(7'h10, 32'h5, "eaddr_a");
    rchk(7'h20, 32'h0, "stat_b");
    $display("test single done");
    d = $random(seed);
    av(1'b1, 7'h0C, 32'h2);
    mem_a(1'b1, 4'h6, d, 1'b0);
    av(1'b1, 7'h0C, 32'h0);
    mem_a(1'b0, 4'h6, d ^ 32'h3, 1'b1);
    rchk(7'h00, 32'h3, "stat_a");
    rchk(7'h08, 32'h2, "cnt_a");
    `CHK("irq", 1'b0, irq)
    av(1'b1, 7'h04, 32'h2);
    @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    mem_a(1'b0, 4'h6, d ^ 32'h3, 1'b1);
    av(1'b1, 7'h00, 32'h3);
    av(1'b1, 7'h08, 32'h0);
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    rchk(7'h08, 32'h0, "cnt_a");
    av(1'b1, 7'h0C, 32'h3);
    mem_a(1'b1, 4'h7, d, 1'b0);
    rchk(7'h0C, 32'h3, "inj_a");
    av(1'b1, 7'h0C, 32'h0);
    $display("test double done");
    e = {$random(seed), $random(seed)};
    mem_b(1'b1, 4'h0, e, 1'b0);
    mem_b(1'b0, 4'h0, e, 1'b0);
    av(1'b1, 7'h2C, 32'h1);
    mem_b(1'b1, 4'h3, e, 1'b0);
    av(1'b1, 7'h2C, 32'h2);
    mem_b(1'b1, 4'h1, e, 1'b0);
    av(1'b1, 7'h2C, 32'h0);
    mem_b(1'b0, 4'h3, e, 1'b0);
    mem_b(1'b0, 4'h1, e ^ 64'h3, 1'b1);
    @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    rchk(7'h20, 32'h3, "stat_b");
    rchk(7'h28, 32'h2, "cnt_b");
    av(1'b1, 7'h20, 32'h3);
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    $display("test transmit done");
    // with the check lane off the flipped bits go through unseen
    av(1'b1, 7'h40, 32'h0);
    av(1'b1, 7'h2C, 32'h2);
    mem_b(1'b1, 4'h2, e, 1'b0);
    av(1'b1, 7'h2C, 32'h0);
    mem_b(1'b0, 4'h2, e ^ 64'h3, 1'b0);
    rchk(7'h20, 32'h0, "stat_b");
    av(1'b1, 7'h40, 32'h1);
    repeat (4) @(posedge clk_sys);
    `CHK("dropped", 2, n_dropped)
    `CHK("used", 5, n_used)
    `CHK("pending", 0, qa.size() + qb.size())
    $display("test lane done");
    final_report();
  end
endmodule
